// ==== verilog/quad_bit_io_port.sv ====
// Purpose: Four-pin bidirectional general-purpose port behind a Wishbone slave.
// Assumes: Pins come from outside the clock domain; pad cells handle drive and levels.
// Notes:   Every output comes straight from a flip-flop.
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module quad_bit_io_port
  import gpio_port_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Wishbone slave.
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [ADR_WIDTH-1:0] adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [DAT_WIDTH-1:0] dat_i,
  output logic      [DAT_WIDTH-1:0] dat_o,
  output logic                      ack_o,
  // Pins.
  input  wire logic [3:0]           pin_in,
  output logic      [3:0]           pin_out,
  output logic      [3:0]           pin_oe_n,
  output logic      [3:0]           pin_slew_limit,
  output logic      [3:0]           pin_threshold_ttl,
  output logic      [3:0]           pin_analog_connect,
  // Peripheral pin select source.
  input  wire logic [3:0]           periph_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser.
  logic [3:0]    pin_meta_ff;
  logic [3:0]    pin_sync_ff;
  logic [3:0]    nxt_pin_meta;
  logic [3:0]    nxt_pin_sync;

  always_comb begin
    nxt_pin_meta = pin_in;
    nxt_pin_sync = pin_meta_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
    end else begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  // Configuration is declared here because the read path below already needs it.
  pin_cfg_type            cfg_ff;
  pin_cfg_type            nxt_cfg;

  // Analog pins read as zero; the pad's chosen threshold already shaped pin_in.
  logic [3:0]    digital_read;
  assign digital_read = pin_sync_ff & ~cfg_ff.ana;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and configuration registers.
  logic                   ack_ff;
  logic                   nxt_ack;
  logic [DAT_WIDTH-1:0]   dat_ff;
  logic [DAT_WIDTH-1:0]   nxt_dat;
  logic                   req;
  logic                   wr_take;
  logic [3:0]             wr_nib;
  logic [3:0]             wr_mask;
  logic [7:0]             ofs;

  assign req     = cyc_i & stb_i;
  assign ofs     = {adr_i[7:2], 2'b00};
  // Writes land at the edge on which the master sees the acknowledge.
  assign wr_take = req & we_i & ack_ff & sel_i[0];
  assign wr_nib  = dat_i[WR_DATA_LSB +: 4];

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_dat = dat_ff;
    if (req & ~ack_ff) begin
      nxt_dat = DAT_ZERO;
      case (ofs)
        PIN_VALUE_OFS:     nxt_dat[3:0] = digital_read;
        PIN_DIRECTION_OFS: nxt_dat[3:0] = cfg_ff.dir;
        OUTPUT_LATCH_OFS:  nxt_dat[3:0] = cfg_ff.latch;
        OPEN_DRAIN_OFS:    nxt_dat[3:0] = cfg_ff.od;
        SLEW_LIMIT_OFS:    nxt_dat[3:0] = cfg_ff.slew;
        THRESHOLD_OFS:     nxt_dat[3:0] = cfg_ff.thr;
        ANALOG_OFS:        nxt_dat[3:0] = cfg_ff.ana;
        PERIPH_SEL_OFS:    nxt_dat[3:0] = cfg_ff.psel;
        default:           nxt_dat      = DAT_ZERO;
      endcase
    end
  end

  // A data write with no mask byte modifies all four bits.
  always_comb begin
    wr_mask = NIBBLE_ONES;
    if (sel_i[1] && (dat_i[WR_MASK_LSB +: 4] != 4'h0)) begin
      wr_mask = dat_i[WR_MASK_LSB +: 4];
    end
  end

  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_take) begin
      case (ofs)
        PIN_VALUE_OFS:     nxt_cfg.latch = (digital_read & ~wr_mask) | (wr_nib & wr_mask);
        PIN_DIRECTION_OFS: nxt_cfg.dir   = wr_nib;
        OUTPUT_LATCH_OFS:  nxt_cfg.latch = wr_nib;
        OPEN_DRAIN_OFS:    nxt_cfg.od    = wr_nib;
        SLEW_LIMIT_OFS:    nxt_cfg.slew  = wr_nib;
        THRESHOLD_OFS:     nxt_cfg.thr   = wr_nib;
        ANALOG_OFS:        nxt_cfg.ana   = wr_nib;
        PERIPH_SEL_OFS:    nxt_cfg.psel  = wr_nib;
        default:           nxt_cfg       = cfg_ff;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= CFG_RST;
      ack_ff <= 1'b0;
      dat_ff <= DAT_ZERO;
    end else begin
      cfg_ff <= nxt_cfg;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drive. Analog selection is left out of the drive path on purpose.
  pad_drive_type pad_ff;
  pad_drive_type nxt_pad;
  logic [3:0]    src;

  always_comb begin
    src = (cfg_ff.psel & periph_out) | (~cfg_ff.psel & cfg_ff.latch);
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (cfg_ff.dir[i]) begin
        nxt_pad.oe_n[i] = 1'b1;
        nxt_pad.out[i]  = 1'b0;
      end else if (cfg_ff.od[i]) begin
        nxt_pad.oe_n[i] = src[i];
        nxt_pad.out[i]  = 1'b0;
      end else begin
        nxt_pad.oe_n[i] = 1'b0;
        nxt_pad.out[i]  = src[i];
      end
    end
    nxt_pad.slew = cfg_ff.slew;
    nxt_pad.thr  = cfg_ff.thr;
    nxt_pad.ana  = cfg_ff.ana;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_ff <= '{out: 4'h0, oe_n: NIBBLE_ONES, slew: SLEW_RST,
                  thr: THRESHOLD_RST, ana: ANALOG_RST};
    end else begin
      pad_ff <= nxt_pad;
    end
  end

  assign dat_o              = dat_ff;
  assign ack_o              = ack_ff;
  assign pin_out            = pad_ff.out;
  assign pin_oe_n           = pad_ff.oe_n;
  assign pin_slew_limit     = pad_ff.slew;
  assign pin_threshold_ttl  = pad_ff.thr;
  assign pin_analog_connect = pad_ff.ana;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_input_off;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((~pin_oe_n & $past(cfg_ff.dir)) == 4'h0);
  endproperty
  a_input_off: assert property (p_input_off) else $error("input pin driven");

  property p_push_pull;
    @(posedge clk) disable iff (rst)
      (cfg_ff.dir == 4'h0 && cfg_ff.od == 4'h0 && cfg_ff.psel == 4'h0)
      |=> (pin_oe_n == 4'h0) && (pin_out == $past(cfg_ff.latch));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("latch not driven");

  property p_read_pins;
    @(posedge clk) disable iff (rst)
      (req && !we_i && !ack_ff && ofs == PIN_VALUE_OFS)
      |=> ack_o && (dat_o == {28'h000_0000, $past(pin_sync_ff & ~cfg_ff.ana)});
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("pin read wrong");

  property p_rmw;
    @(posedge clk) disable iff (rst)
      (wr_take && ofs == PIN_VALUE_OFS)
      |=> cfg_ff.latch == $past((digital_read & ~wr_mask) | (wr_nib & wr_mask));
  endproperty
  a_rmw: assert property (p_rmw) else $error("merge into latch wrong");

  property p_open_drain;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((~pin_oe_n & pin_out & $past(cfg_ff.od)) == 4'h0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain sourced");

  property p_analog_zero;
    @(posedge clk) disable iff (rst)
      (req && !we_i && !ack_ff && ofs == PIN_VALUE_OFS && cfg_ff.ana == 4'hF)
      ##1 (cfg_ff.ana == 4'hF) |-> (dat_o == DAT_ZERO);
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read one");

  property p_analog_drive;
    @(posedge clk) disable iff (rst)
      (cfg_ff.ana[0] && !cfg_ff.dir[0] && !cfg_ff.od[0]) |=> !pin_oe_n[0];
  endproperty
  a_analog_drive: assert property (p_analog_drive) else $error("analog killed drive");

  property p_slew_follow;
    @(posedge clk) disable iff (rst)
      (wr_take && ofs == SLEW_LIMIT_OFS) |=> ##1 (pin_slew_limit == $past(wr_nib, 2));
  endproperty
  a_slew_follow: assert property (p_slew_follow) else $error("slew not applied");

  property p_readback;
    @(posedge clk) disable iff (rst)
      (req && !we_i && !ack_ff && ofs == PIN_DIRECTION_OFS)
      |=> (dat_o == {28'h000_0000, $past(cfg_ff.dir)});
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_input_low;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((pin_out & $past(cfg_ff.dir)) == 4'h0);
  endproperty
  a_input_low: assert property (p_input_low) else $error("input pin drive value high");

  property p_pull_drive;
    @(posedge clk) disable iff (rst)
      1'b1 |=> ((pin_oe_n & ~$past(cfg_ff.dir) & ~$past(cfg_ff.od)) == 4'h0);
  endproperty
  a_pull_drive: assert property (p_pull_drive) else $error("push-pull pin released");

  // Push-pull output pins without peripheral select must follow the latch, whatever the analog select says.
  property p_latch_source;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (((pin_out ^ $past(cfg_ff.latch))
                 & ~$past(cfg_ff.dir | cfg_ff.od | cfg_ff.psel)) == 4'h0);
  endproperty
  a_latch_source: assert property (p_latch_source) else $error("pin not from latch");

  property p_thr_follow;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (pin_threshold_ttl == $past(cfg_ff.thr));
  endproperty
  a_thr_follow: assert property (p_thr_follow) else $error("threshold not applied");

  property p_analog_follow;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (pin_analog_connect == $past(cfg_ff.ana));
  endproperty
  a_analog_follow: assert property (p_analog_follow) else $error("analog not connected");

  property p_reset_analog;
    @(posedge clk) disable iff (rst)
      $fell(rst) |-> (cfg_ff.ana == ANALOG_RST) && (pin_analog_connect == ANALOG_RST);
  endproperty
  a_reset_analog: assert property (p_reset_analog) else $error("analog reset wrong");

  property p_upper_zero;
    @(posedge clk) disable iff (rst)
      ack_o |-> (dat_o[31:4] == 28'h000_0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

  c_all_push_pull: cover property (@(posedge clk) disable iff (rst)
    cfg_ff.dir == 4'h0 && cfg_ff.od == 4'h0 && cfg_ff.psel == 4'h0);
  c_periph_drive: cover property (@(posedge clk) disable iff (rst)
    (cfg_ff.psel & ~cfg_ff.dir & ~pin_oe_n) != 4'h0);
  c_rmw_write: cover property (@(posedge clk) disable iff (rst)
    wr_take && ofs == PIN_VALUE_OFS && wr_mask != NIBBLE_ONES);
  c_open_drain_low: cover property (@(posedge clk) disable iff (rst)
    cfg_ff.od[0] && !pin_oe_n[0]);
  c_analog_output: cover property (@(posedge clk) disable iff (rst)
    pin_analog_connect[1] && !pin_oe_n[1]);

endmodule

// ==== verilog/gpio_port_pkg.sv ====
// Purpose: Shared constants and types for the four-pin general-purpose port.
// Assumes: Classic Wishbone slave with 32-bit data, one aligned word per register.
// Notes:   Register offsets are byte addresses.
package gpio_port_pkg;

  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned ADR_WIDTH = 8;
  localparam int unsigned DAT_WIDTH = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] PIN_VALUE_OFS    = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_OFS = 8'h04;
  localparam logic [7:0] OUTPUT_LATCH_OFS = 8'h08;
  localparam logic [7:0] OPEN_DRAIN_OFS   = 8'h0C;
  localparam logic [7:0] SLEW_LIMIT_OFS   = 8'h10;
  localparam logic [7:0] THRESHOLD_OFS    = 8'h14;
  localparam logic [7:0] ANALOG_OFS       = 8'h18;
  localparam logic [7:0] PERIPH_SEL_OFS   = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of a write to the pin value register.
  localparam int unsigned WR_DATA_LSB = 0;
  localparam int unsigned WR_MASK_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [3:0] DIRECTION_RST  = 4'hF;
  localparam logic [3:0] LATCH_RST      = 4'h0;
  localparam logic [3:0] OPEN_DRAIN_RST = 4'h0;
  localparam logic [3:0] SLEW_RST       = 4'hF;
  localparam logic [3:0] THRESHOLD_RST  = 4'h0;
  localparam logic [3:0] ANALOG_RST     = 4'hF;
  localparam logic [3:0] PERIPH_SEL_RST = 4'h0;

  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;
  localparam logic [3:0]  NIBBLE_ONES = 4'hF;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin configuration held by software.
  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] latch;
    logic [3:0] od;
    logic [3:0] slew;
    logic [3:0] thr;
    logic [3:0] ana;
    logic [3:0] psel;
  } pin_cfg_type;

  localparam pin_cfg_type CFG_RST = '{dir: DIRECTION_RST, latch: LATCH_RST,
                                      od: OPEN_DRAIN_RST, slew: SLEW_RST,
                                      thr: THRESHOLD_RST, ana: ANALOG_RST,
                                      psel: PERIPH_SEL_RST};

  // Pad drive bundle sent to the four pins.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
    logic [3:0] slew;
    logic [3:0] thr;
    logic [3:0] ana;
  } pad_drive_type;

endpackage

// ==== bench/pin_board_model.sv ====
// Purpose: Board around the four pins: pull-ups and an optional outside driver.
// Assumes: The outside driver is only enabled on pins whose port driver is off.
// Notes:   A released pin without outside drive floats up to the pull-up.
`timescale 1ns/1ps
module pin_board_model (
  // Port side.
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  // Outside driver.
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  // Resolved level.
  output logic      [3:0] pin_level
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pull-ups stop an open-drain release from showing the last driven low.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pin_oe_n[i]) begin
        pin_level[i] = pin_out[i];
      end else begin
        pin_level[i] = ext_en[i] ? ext_val[i] : 1'b1;
      end
    end
  end
endmodule

// ==== bench/test_quad_bit_io_port.sv ====
// Purpose: Self-checking bench for the four-pin port.
// Assumes: Board model resolves pin levels; no outside contention.
// Notes:   Waits five cycles after configuration for the input synchroniser.
`timescale 1ns/1ps
module test_quad_bit_io_port;
  import gpio_port_pkg::*;
  logic        clk, rst, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel, lvl, pout, poe_n, pslew, pthr, pana, periph, ext_en, ext_val;
  logic [3:0]  src, d, m, mk;
  logic [31:0] dat, rdat, q, v, expv;
  logic [3:0]  c [8];
  logic [3:0]  rv [8] = '{4'h0, DIRECTION_RST, LATCH_RST, OPEN_DRAIN_RST, SLEW_RST,
                          THRESHOLD_RST, ANALOG_RST, PERIPH_SEL_RST};
  int          fail_count, checks, cycles;

  quad_bit_io_port uut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .pin_in(lvl),
    .pin_out(pout), .pin_oe_n(poe_n), .pin_slew_limit(pslew), .pin_threshold_ttl(pthr),
    .pin_analog_connect(pana), .periph_out(periph));
  pin_board_model board (.pin_out(pout), .pin_oe_n(poe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_level(lvl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      close_out();
    end
  end

  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp4(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  // Single classic cycle; read data is taken at the edge that sees ack.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= wd;
    sel <= 4'hF;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [3:0] level_of(logic [3:0] oe_n, o, en, val);
    return (~oe_n & o) | (oe_n & ((en & val) | ~en));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    dat = 32'h0000_0000; periph = 4'h0; ext_en = 4'h0; ext_val = 4'h0;
    void'($urandom(32'h718c496a));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp4(poe_n, 4'hF);
    cmp4(pana, 4'hF);
    for (int i = 1; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0000_0000, q);
      cmp32(q, {28'h0, rv[i]});
    end
    wb(1'b0, PIN_VALUE_OFS, 32'h0000_0000, q);
    cmp32(q, 32'h0000_0000);
    wb(1'b0, 8'h20, 32'h0000_0000, q);
    cmp32(q, 32'h0000_0000);
    $display("test reset finished");
    for (int n = 0; n < 24; n++) begin
      // Early rounds clear analog select before digital use; threshold moves idle only.
      for (int i = 1; i < 8; i++) begin
        v = $urandom;
        if (i == 6 && n < 8) v[3:0] = 4'h0;
        if (i == 3 && n < 2) v[3:0] = n ? 4'h0 : 4'hF;
        if ((i == 1 || i == 7) && n == 1) v[3:0] = 4'h0;
        wb(1'b1, 8'(i * 4), v, q);
        c[i] = v[3:0];
        wb(1'b0, 8'(i * 4), 32'h0000_0000, q);
        cmp32(q, {28'h0, c[i]});
      end
      ext_en  <= 4'($urandom) & c[1];
      ext_val <= 4'($urandom);
      periph  <= 4'($urandom);
      repeat (5) @(posedge clk);
      src = (c[7] & periph) | (~c[7] & c[2]);
      cmp4(poe_n, c[1] | (c[3] & src));
      cmp4(pout, ~c[1] & ~c[3] & src);
      cmp4(pslew, c[4]);
      cmp4(pthr, c[5]);
      cmp4(pana, c[6]);
      expv = {28'h0, level_of(c[1] | (c[3] & src), ~c[1] & ~c[3] & src,
                              ext_en, ext_val) & ~c[6]};
      wb(1'b0, PIN_VALUE_OFS, 32'h0000_0000, q);
      cmp32(q, expv);
      d = 4'($urandom);
      m = (n == 2) ? 4'h0 : 4'($urandom);
      mk = (m == 4'h0) ? 4'hF : m;
      wb(1'b1, PIN_VALUE_OFS, {20'h0, m, 4'h0, d}, q);
      wb(1'b0, OUTPUT_LATCH_OFS, 32'h0000_0000, q);
      cmp32(q, {28'h0, (expv[3:0] & ~mk) | (d & mk)});
    end
    $display("test random finished");
    close_out();
  end
endmodule
